// ### design/uxp_pkg.sv
package uxp_pkg;
	localparam int NPORT = 8;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DIV = 8'h04;
	localparam logic [7:0] OFF_THR = 8'h08;
	localparam logic [7:0] OFF_TXDATA = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_STRAP = 8'h14;
	localparam logic [7:0] OFF_LINE = 8'h18;
	// ----------------------------------------
	// fields
	// ----------------------------------------
	localparam int CTL_DTR_EN = 0;
	localparam int CTL_RTS_EN = 1;
	localparam int CTL_CTS_EN = 2;
	localparam int CTL_DSR_EN = 3;
	localparam int CTL_MRTS_LSB = 16;
	localparam int CTL_MDTR_LSB = 24;
	localparam int THR_UP_LSB = 0;
	localparam int THR_LO_LSB = 8;
	localparam int TXD_PORT_LSB = 8;
	localparam int TXD_FC_BIT = 11;
	localparam int LINE_BUSY_LSB = 8;
	localparam int LINE_HOLD_LSB = 16;
	localparam int STRAP_DONE_BIT = 4;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] DIV_RST = 16'h015b;
	localparam logic [15:0] THR_RST = 16'h2060;
	// ----------------------------------------
	// framing and timing
	// ----------------------------------------
	localparam logic [3:0] FRAME_BITS = 4'ha;
	localparam int STRAP_TIME_NS = 1000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int STRAP_CYC_INT = (STRAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] STRAP_CYCLES = 6'(STRAP_CYC_INT);
	typedef enum logic {
		PH_STRAP = 1'b0,
		PH_RUN = 1'b1
	} uxp_phase_t;
endpackage

// ### design/uxp_uart_pins.sv
// Overview of operation
// - every port frames each character with a start bit and a stop bit
// - auto terminal-ready asserts at upper threshold, releases below lower threshold
// - auto request-to-send deasserts at upper threshold, reasserts below lower threshold
// - auto clear-to-send loss finishes current character, then idles until reasserted
// - auto data-set-ready loss finishes current character, then idles until reasserted
// - flow-control characters are sent regardless of clear-to-send and data-set-ready
// - port 0 request-to-send strap high at start-up skips the EEPROM preload
// - each port takes an active-low carrier detect, usable as general input
// - each port takes an active-low ring indicator, low meaning asserted
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
module uxp_uart_pins (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] serial_rx_in,
	input wire logic [7:0] cts_n,
	input wire logic [7:0] dsr_n,
	input wire logic [7:0] carrier_detect_n,
	input wire logic [7:0] ring_indicator_n,
	input wire logic [63:0] rx_fill_level,
	output logic [7:0] serial_tx_out,
	output logic [7:0] serial_tx_oe,
	input wire logic serial_tx1_in,
	output logic [7:0] rts_n_out,
	output logic [7:0] rts_n_oe,
	input wire logic [1:0] rts_n_in,
	output logic [7:0] dtr_n_out,
	output logic [7:0] dtr_n_oe,
	input wire logic dtr0_n_in,
	output logic eeprom_bypass
);
	import uxp_pkg::*;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// change counts once second and third stage agree
	function automatic logic [39:0] agree(input logic [39:0] s2, input logic [39:0] s3,
		input logic [39:0] old);
		agree = (s2 & s3) | (old & (s2 | s3));
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [39:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
	logic [39:0] pin_raw;
	logic [39:0] st_raw;
	logic [39:0] st_s1_q, st_s2_q, st_s3_q, st_f_q;
	assign pin_raw = {ring_indicator_n, carrier_detect_n, dsr_n, cts_n, serial_rx_in};
	assign st_raw = {36'h0, dtr0_n_in, serial_tx1_in, rts_n_in};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_q <= '1;
			pin_s2_q <= '1;
			pin_s3_q <= '1;
			pin_f_q <= '1;
			st_s1_q <= '0;
			st_s2_q <= '0;
			st_s3_q <= '0;
			st_f_q <= '0;
		end else if (ce) begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_f_q <= agree(pin_s2_q, pin_s3_q, pin_f_q);
			st_s1_q <= st_raw;
			st_s2_q <= st_s1_q;
			st_s3_q <= st_s2_q;
			st_f_q <= agree(st_s2_q, st_s3_q, st_f_q);
		end
	end

	wire logic [7:0] rx_lvl = pin_f_q[7:0];
	wire logic [7:0] cts_act = ~pin_f_q[15:8];
	wire logic [7:0] dsr_act = ~pin_f_q[23:16];
	wire logic [7:0] dcd_act = ~pin_f_q[31:24];
	wire logic [7:0] ri_act = ~pin_f_q[39:32];

	// ----------------------------------------
	// start-up strap window
	// ----------------------------------------
	uxp_phase_t phase_q;
	logic [5:0] scnt_q;
	logic [3:0] strap_q;
	logic oe_q;

	// pins stay released during the window so the straps can be read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= PH_STRAP;
			scnt_q <= '0;
			strap_q <= '0;
			oe_q <= 1'b0;
		end else if (ce) begin
			case (phase_q)
				PH_STRAP: begin
					scnt_q <= 6'(scnt_q + 6'h1);
					if (scnt_q == 6'(STRAP_CYCLES - 6'h1)) begin
						strap_q <= st_f_q[3:0];
						oe_q <= 1'b1;
						phase_q <= PH_RUN;
					end
				end
				default: begin
					phase_q <= PH_RUN;
				end
			endcase
		end
	end
	assign eeprom_bypass = strap_q[0];
	assign serial_tx_oe = {NPORT{oe_q}};
	assign rts_n_oe = {NPORT{oe_q}};
	assign dtr_n_oe = {NPORT{oe_q}};
	wire logic run = (phase_q == PH_RUN);

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	logic [31:0] ctrl_q;
	logic [15:0] div_q, thr_q;
	logic [15:0] bcnt_q;
	wire logic tick = run && (bcnt_q == 16'h0);
	wire logic [7:0] thr_up = thr_q[THR_UP_LSB +: 8];
	wire logic [7:0] thr_lo = thr_q[THR_LO_LSB +: 8];

	// ----------------------------------------
	// two-entry transmit buffer
	// ----------------------------------------
	logic [11:0] buf_q [2];
	logic wptr_q, rptr_q;
	logic [1:0] cnt_q;
	logic [7:0] busy, allowed;
	wire logic [11:0] head = buf_q[rptr_q];
	wire logic [2:0] head_port = head[TXD_PORT_LSB +: 3];
	wire logic in_ready = (cnt_q != 2'h2);
	wire logic out_valid = (cnt_q != 2'h0);
	wire logic out_ready = tick && !busy[head_port] && allowed[head_port];
	wire logic pop = out_valid && out_ready;
	logic push;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_q <= 1'b0;
			rptr_q <= 1'b0;
			cnt_q <= '0;
			buf_q[0] <= '0;
			buf_q[1] <= '0;
		end else if (ce) begin
			if (push) begin
				buf_q[wptr_q] <= pwdata[11:0];
				wptr_q <= ~wptr_q;
			end
			if (pop) begin
				rptr_q <= ~rptr_q;
			end
			if (push && !pop) begin
				cnt_q <= 2'(cnt_q + 2'h1);
			end else if (pop && !push) begin
				cnt_q <= 2'(cnt_q - 2'h1);
			end
		end
	end

	// shared baud tick; a divisor of zero behaves as one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bcnt_q <= '0;
		end else if (ce && run) begin
			if (bcnt_q == 16'h0) begin
				bcnt_q <= (div_q == 16'h0) ? 16'h0 : 16'(div_q - 16'h1);
			end else begin
				bcnt_q <= 16'(bcnt_q - 16'h1);
			end
		end
	end

	// ----------------------------------------
	// per-port transmitter and flow control
	// ----------------------------------------
	logic [7:0] hold;
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		logic [9:0] sh_q;
		logic [3:0] bits_q;
		logic hold_q, rts_q, dtr_q;
		wire logic [7:0] lvl = rx_fill_level[p*8 +: 8];
		wire logic load = pop && (head_port == 3'(p));
		// hold-off only blocks the start of a character, never cuts one
		assign allowed[p] = head[TXD_FC_BIT] ||
			((!ctrl_q[CTL_CTS_EN] || cts_act[p]) &&
			(!ctrl_q[CTL_DSR_EN] || dsr_act[p]));
		assign busy[p] = (bits_q != 4'h0);
		assign hold[p] = hold_q;
		assign serial_tx_out[p] = sh_q[0];
		assign rts_n_out[p] = rts_q;
		assign dtr_n_out[p] = dtr_q;

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				sh_q <= '1;
				bits_q <= '0;
			end else if (ce) begin
				if (load) begin
					sh_q <= {1'b1, head[7:0], 1'b0};
					bits_q <= FRAME_BITS;
				end else if (tick && busy[p]) begin
					sh_q <= {1'b1, sh_q[9:1]};
					bits_q <= 4'(bits_q - 4'h1);
				end
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				hold_q <= 1'b0;
				rts_q <= 1'b1;
				dtr_q <= 1'b1;
			end else if (ce) begin
				if (lvl >= thr_up) begin
					hold_q <= 1'b1;
				end else if (lvl < thr_lo) begin
					hold_q <= 1'b0;
				end
				rts_q <= ctrl_q[CTL_RTS_EN] ? hold_q : ~ctrl_q[CTL_MRTS_LSB + p];
				dtr_q <= ctrl_q[CTL_DTR_EN] ? ~hold_q : ~ctrl_q[CTL_MDTR_LSB + p];
			end
		end
	end

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	logic [31:0] rd;
	logic err;
	wire logic h_ctrl = hit(paddr, OFF_CTRL);
	wire logic h_div = hit(paddr, OFF_DIV);
	wire logic h_thr = hit(paddr, OFF_THR);
	wire logic h_txd = hit(paddr, OFF_TXDATA);
	wire logic acc = psel && penable && !pready;
	wire logic stall = pwrite && h_txd && !in_ready;
	wire logic done = psel && penable && pready && pwrite && !pslverr;
	assign push = done && h_txd;

	always_comb begin
		rd = 32'h0;
		err = 1'b0;
		if (h_ctrl) begin
			rd = ctrl_q;
		end else if (h_div) begin
			rd = {16'h0, div_q};
		end else if (h_thr) begin
			rd = {16'h0, thr_q};
		end else if (h_txd) begin
			rd = {30'h0, cnt_q};
		end else if (hit(paddr, OFF_STATUS)) begin
			rd = {ri_act, dcd_act, dsr_act, cts_act};
			err = pwrite;
		end else if (hit(paddr, OFF_STRAP)) begin
			rd = {27'h0, run, strap_q};
			err = pwrite;
		end else if (hit(paddr, OFF_LINE)) begin
			rd = {8'h0, hold, busy, rx_lvl};
			err = pwrite;
		end else begin
			err = 1'b1;
		end
	end

	// one wait state; a full buffer keeps pready low, pushing back against software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (ce) begin
			pready <= acc && !stall;
			pslverr <= acc && !stall && err;
			prdata <= (acc && !stall && !pwrite) ? rd : 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RST;
			div_q <= DIV_RST;
			thr_q <= THR_RST;
		end else if (ce && done) begin
			if (h_ctrl) begin
				ctrl_q <= pwdata;
			end else if (h_div) begin
				div_q <= pwdata[15:0];
			end else if (h_thr) begin
				thr_q <= pwdata[15:0];
			end
		end
	end
endmodule
`default_nettype wire

// ### test/uxp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module uxp_monitor
	import uxp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [63:0] rx_fill_level,
	input wire logic [7:0] serial_tx_out,
	input wire logic [7:0] serial_tx_oe,
	input wire logic [7:0] rts_n_out,
	input wire logic [7:0] rts_n_oe,
	input wire logic [1:0] rts_n_in,
	input wire logic [7:0] dtr_n_out,
	input wire logic [7:0] dtr_n_oe,
	input wire logic eeprom_bypass
);
	logic [31:0] ctl_q;
	logic [15:0] thr_q;
	logic [5:0] n_q;
	logic strap_q;
	wire logic wr_ok = psel & penable & pready & pwrite & !pslverr;
	wire logic hi = rx_fill_level[7:0] >= thr_q[7:0];
	wire logic lo = rx_fill_level[7:0] < thr_q[15:8];
	// shadow of ctrl and thresholds, so the checker needs no hierarchy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= CTRL_RST;
			thr_q <= THR_RST;
			n_q <= 6'h0;
			strap_q <= 1'b0;
		end else begin
			if (n_q != 6'h3f) n_q <= n_q + 6'h1;
			if (n_q == 6'h14) strap_q <= rts_n_in[0];
			if (wr_ok && paddr == OFF_CTRL) ctl_q <= pwdata;
			if (wr_ok && paddr == OFF_THR) thr_q <= pwdata[15:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_auto(en, cond);
		en && cond ##1 en;
	endsequence
	property p_idle_high; !serial_tx_oe[0] |-> serial_tx_out[0]; endproperty
	a_idle_high: assert property (p_idle_high) else $error("tx not idle high");
	property p_rts_up; s_auto(ctl_q[1], hi) |=> rts_n_out[0]; endproperty
	a_rts_up: assert property (p_rts_up) else $error("rts not released");
	property p_rts_lo; s_auto(ctl_q[1], lo) |=> !rts_n_out[0]; endproperty
	a_rts_lo: assert property (p_rts_lo) else $error("rts not asserted");
	property p_dtr_up; s_auto(ctl_q[0], hi) |=> !dtr_n_out[0]; endproperty
	a_dtr_up: assert property (p_dtr_up) else $error("dtr not asserted");
	property p_dtr_lo; s_auto(ctl_q[0], lo) |=> dtr_n_out[0]; endproperty
	a_dtr_lo: assert property (p_dtr_lo) else $error("dtr not released");
	property p_oe_win;
		n_q < 6'h27 |-> rts_n_oe == 8'h0 && serial_tx_oe == 8'h0 && dtr_n_oe == 8'h0;
	endproperty
	a_oe_win: assert property (p_oe_win) else $error("pin driven in strap time");
	property p_oe_run;
		n_q > 6'h29 |-> &rts_n_oe && &serial_tx_oe && &dtr_n_oe;
	endproperty
	a_oe_run: assert property (p_oe_run) else $error("pin not driven");
	property p_bypass; n_q > 6'h29 |-> eeprom_bypass == strap_q; endproperty
	a_bypass: assert property (p_bypass) else $error("bypass strap wrong");
endmodule
bind uxp_uart_pins uxp_monitor uxp_monitor_inst (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .rx_fill_level, .serial_tx_out,
	.serial_tx_oe, .rts_n_out, .rts_n_oe, .rts_n_in, .dtr_n_out, .dtr_n_oe, .eeprom_bypass);
`default_nettype wire

// ### test/uxp_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module uxp_far_end (
	input wire logic bypass_strap,
	input wire logic [7:0] serial_tx_out,
	input wire logic [7:0] serial_tx_oe,
	input wire logic [7:0] rts_n_out,
	input wire logic [7:0] rts_n_oe,
	input wire logic [7:0] dtr_n_out,
	input wire logic [7:0] dtr_n_oe,
	output logic [7:0] serial_rx_in,
	output logic serial_tx1_in,
	output logic [1:0] rts_n_in,
	output logic dtr0_n_in
);
	// remote echoes framed characters back, idling high while the pin is released
	assign serial_rx_in = serial_tx_out | ~serial_tx_oe;
	// pull-downs: undriven debug straps read low
	assign serial_tx1_in = serial_tx_oe[1] & serial_tx_out[1];
	assign rts_n_in[1] = rts_n_oe[1] & rts_n_out[1];
	assign dtr0_n_in = dtr_n_oe[0] & dtr_n_out[0];
	assign rts_n_in[0] = rts_n_oe[0] ? rts_n_out[0] : bypass_strap;
endmodule
`default_nettype wire

// ### test/uxp_uart_pins_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uxp_uart_pins_tb;
	import uxp_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ce = 1'b1;
	logic bypass_strap = 1'b1, pready, pslverr, err, serial_tx1_in, dtr0_n_in, eeprom_bypass;
	logic [7:0] paddr = 8'h0, cts_n = 8'h0, dsr_n = 8'h0;
	logic [7:0] carrier_detect_n = 8'hff, ring_indicator_n = 8'hff;
	logic [7:0] serial_rx_in, serial_tx_out, serial_tx_oe, rts_n_out, rts_n_oe, dtr_n_out, dtr_n_oe;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [63:0] rx_fill_level = 64'h0;
	logic [1:0] rts_n_in;
	logic [9:0] frame;
	logic [7:0] lv [4] = '{8'h60, 8'h40, 8'h1f, 8'h20};
	int err_count = 0, total_checks = 0, cyc = 0, k;
	uxp_uart_pins uxp_uart_pins_inst (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .serial_rx_in, .cts_n, .dsr_n, .carrier_detect_n,
		.ring_indicator_n, .rx_fill_level, .serial_tx_out, .serial_tx_oe, .serial_tx1_in,
		.rts_n_out, .rts_n_oe, .rts_n_in, .dtr_n_out, .dtr_n_oe, .dtr0_n_in, .eeprom_bypass);
	uxp_far_end uxp_far_end_inst (.bypass_strap, .serial_tx_out, .serial_tx_oe, .rts_n_out,
		.rts_n_oe, .dtr_n_out, .dtr_n_oe, .serial_rx_in, .serial_tx1_in, .rts_n_in, .dtr0_n_in);
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			close_out();
		end
	end
	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// request held until pready is sampled, idle cycle after each transfer
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(w, e, rd);
	endtask
	// samples each bit in its third cycle, divisor 4
	task automatic grab(input int p);
		repeat (2000) begin
			@(posedge pclk);
			if (serial_tx_out[p] === 1'b0) break;
		end
		repeat (2) @(posedge pclk);
		for (int i = 0; i < 10; i++) begin
			frame[i] = serial_tx_out[p];
			repeat (4) @(posedge pclk);
		end
	endtask
	task automatic quiet(input int p);
		int lows;
		lows = 0;
		repeat (200) begin
			@(posedge pclk);
			if (serial_tx_out[p] !== 1'b1) lows++;
		end
		chk("held line", 32'h0, lows);
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (50) @(posedge pclk);
		rchk("strap", OFF_STRAP, 32'h11);
		rchk("ctrl", OFF_CTRL, CTRL_RST);
		rchk("div", OFF_DIV, {16'h0, DIV_RST});
		rchk("thr", OFF_THR, {16'h0, THR_RST});
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped err", 32'h1, err);
		apb(1'b1, OFF_STATUS, 32'hffff_ffff);
		chk("ro err", 32'h1, err);
		cts_n <= 8'h5a;
		dsr_n <= 8'h3c;
		carrier_detect_n <= 8'h96;
		ring_indicator_n <= 8'h0f;
		repeat (8) @(posedge pclk);
		rchk("status", OFF_STATUS, 32'hf069_c3a5);
		cts_n <= 8'h0;
		dsr_n <= 8'h0;
		apb(1'b1, OFF_CTRL, 32'h3);
		for (k = 0; k < 4; k++) begin
			rx_fill_level[7:0] <= lv[k];
			repeat (4) @(posedge pclk);
			chk("rts0", 32'(k < 2), rts_n_out[0]);
			chk("dtr0", 32'(k >= 2), dtr_n_out[0]);
		end
		apb(1'b1, OFF_CTRL, 32'h0180_0000);
		repeat (3) @(posedge pclk);
		chk("manual pins", 32'hfe7f, {dtr_n_out, rts_n_out});
		// clock enable low must freeze the pin synchronisers
		ce <= 1'b0;
		ring_indicator_n <= 8'h00;
		repeat (8) @(posedge pclk);
		ce <= 1'b1;
		rchk("frozen", OFF_STATUS, 32'hf069_ffff);
		repeat (8) @(posedge pclk);
		rchk("thawed", OFF_STATUS, 32'hff69_ffff);
		apb(1'b1, OFF_DIV, 32'h4);
		apb(1'b1, OFF_TXDATA, 32'h0a5);
		grab(0);
		chk("frame", {1'b1, 8'ha5, 1'b0}, frame);
		for (k = 0; k < 2; k++) begin
			apb(1'b1, OFF_CTRL, 32'h4 << k);
			if (k == 0) cts_n[1] <= 1'b1;
			else dsr_n[2] <= 1'b1;
			repeat (8) @(posedge pclk);
			apb(1'b1, OFF_TXDATA, 32'h811 | ((k + 1) << 8));
			grab(k + 1);
			chk("flow char", {1'b1, 8'h11, 1'b0}, frame);
			apb(1'b1, OFF_TXDATA, 32'h03c | ((k + 1) << 8));
			quiet(k + 1);
			rchk("entries", OFF_TXDATA, 32'h1);
			cts_n <= 8'h0;
			dsr_n <= 8'h0;
			grab(k + 1);
			chk("held char", {1'b1, 8'h3c, 1'b0}, frame);
		end
		rchk("line", OFF_LINE, 32'h0000_00ff);
		close_out();
	end
endmodule
`default_nettype wire
